// >>> inc/enc_cal_pkg.sv
// Constants for the encoder feedback and calibration block.
// Assumes a 100 MHz clock and a classic Wishbone bus.
package enc_cal_pkg;
    localparam int unsigned CLK_HZ       = 100_000_000;   // System clock rate
    localparam int unsigned GATE_TIME_MS = 10;            // Speed gate interval in ms
    localparam int unsigned GATE_CYCLES  = GATE_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned MAX_PULSE_HZ = 100_000;       // Highest encoder rate
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;  // Mode and option bits
    localparam logic [7:0] OFS_LINES     = 8'h04;  // lines_per_rev
    localparam logic [7:0] OFS_RATIO     = 8'h08;  // motor_to_encoder_ratio, Q8.8
    localparam logic [7:0] OFS_FS_RPM    = 8'h0c;  // full_scale_speed in rpm
    localparam logic [7:0] OFS_FLD_TRIM  = 8'h10;  // Field trim, Q2.14
    localparam logic [7:0] OFS_ARM_TRIM  = 8'h14;  // Armature trim, Q2.14
    localparam logic [7:0] OFS_TACH_TRIM = 8'h18;  // Tacho trim, Q2.14
    localparam logic [7:0] OFS_IR_COMP   = 8'h1c;  // resistive_drop_comp, Q0.16
    localparam logic [7:0] OFS_FS_ARM    = 8'h20;  // full_speed_armature_volts
    localparam logic [7:0] OFS_ENC_RPM   = 8'h24;  // encoder_speed_monitor (ro)
    localparam logic [7:0] OFS_MOT_PCT   = 8'h28;  // motor_speed_percent (ro)
    localparam logic [7:0] OFS_SPD_FB    = 8'h2c;  // Selected speed feedback (ro)
    // Control field positions
    localparam int unsigned CTRL_QUAD    = 0;   // Quadrature enable
    localparam int unsigned CTRL_INV     = 1;   // direction_invert
    localparam int unsigned CTRL_ORIENT  = 2;   // shaft_orient_lock
    localparam int unsigned CTRL_MODE_LO = 4;   // Feedback mode, 3 bits
    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0001;  // Quadrature selected
    localparam logic [15:0] LINES_RST  = 16'h0400;
    localparam logic [15:0] RATIO_RST  = 16'h0100;       // Ratio of 1.0
    localparam logic [15:0] FS_RPM_RST = 16'h07d0;
    localparam logic [15:0] FS_ARM_RST = 16'h0190;
    localparam logic [15:0] TRIM_MIN   = 16'h4000;       // 1.0000
    localparam logic [15:0] TRIM_MAX   = 16'h4666;       // 1.1000
    localparam logic [15:0] IR_RST     = 16'h0000;
    // Percent scale: 100.00 % reads as 10000
    localparam logic signed [31:0] PCT_FULL = 32'sd10000;
    // Feedback modes
    typedef enum logic [2:0] {
        FB_ARM_VOLTS = 3'h0,
        FB_TACHO     = 3'h1,
        FB_ENCODER   = 3'h2,
        FB_ENC_ARM   = 3'h3,
        FB_ENC_TACHO = 3'h4
    } fb_mode_t;
endpackage : enc_cal_pkg

// >>> core/encoder_feedback_calibration.sv
// Encoder decoder, speed measurement and feedback calibration.
// Assumes synchronous inputs except the encoder pins, and a
// classic Wishbone master.
//
// Operation
// - Pulse-with-sign: count pulses, level gives direction
// - Quadrature: A leading B means forward
// - Invert sign when direction_invert set
// - Quadrature decoding selected after reset
// - lines_per_rev scales pulse frequency to speed
// - Decode correctly up to maximum pulse rate
// - Motor percent uses ratio, full speed 100%
// - Speed outputs come only from encoder pulses
// - No pulses gives zero speed outputs
// - Modes 3/4 single-line: sign from analog
// - No heavy filtering on encoder inputs
// - Gain trims clamped between unity and max
// - Subtract resistive drop from armature volts; code does it only in modes 0/3 or with field weakening
// - Full-speed armature volts equals 100% feedback
// - Combined modes: analog dynamic, encoder trims
`timescale 1ns/10ps
module encoder_feedback_calibration
#(
    parameter int unsigned GATE_CYCLES = enc_cal_pkg::GATE_CYCLES  // Gate length
)
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               pulse_input_terminal_i,      // Pulse or A train
    input  wire logic               direction_input_terminal_i,  // Sign or B train
    input  wire logic signed [15:0] arm_volts_i,        // Raw armature volts
    input  wire logic signed [15:0] arm_current_i,      // Armature current
    input  wire logic signed [15:0] tacho_fb_i,         // Tacho, 0.01 % units
    input  wire logic signed [15:0] field_fb_i,         // Field current feedback
    input  wire logic               field_weak_i,       // Field weakening active
    input  wire logic [31:0]        wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_we_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    output logic signed [31:0]      encoder_speed_monitor_o,  // rpm
    output logic signed [31:0]      motor_speed_percent_o,    // 0.01 % units
    output logic signed [31:0]      speed_feedback_o,         // 0.01 % units
    output logic signed [31:0]      arm_fb_percent_o,         // 0.01 % units
    output logic signed [31:0]      tacho_fb_trimmed_o,
    output logic signed [31:0]      field_fb_trimmed_o
);
    import enc_cal_pkg::*;

    // Trim multiply, Q2.14 factor
    function automatic logic signed [31:0] trim_mul(input logic signed [31:0] v,
                                                    input logic [15:0] t);
        logic signed [47:0] p;
        p = 48'(v) * $signed({1'b0, t});
        return 32'(p >>> 14);
    endfunction : trim_mul
    // Clamp a written trim into its legal band
    function automatic logic [15:0] clamp_trim(input logic [15:0] t);
        if (t < TRIM_MIN)
            return TRIM_MIN;
        else if (t > TRIM_MAX)
            return TRIM_MAX;
        else
            return t;
    endfunction : clamp_trim
    // Signed divide with zero guard
    function automatic logic signed [31:0] sdiv(input logic signed [63:0] n,
                                                input logic signed [63:0] d);
        logic signed [63:0] q;
        q = (d == 64'sd0) ? 64'sd0 : n / d;
        return 32'(q);
    endfunction : sdiv
    // Registers written by software
    logic [31:0] ctrl_ff,    nxt_ctrl;
    logic [15:0] lines_ff,   nxt_lines;
    logic [15:0] ratio_ff,   nxt_ratio;
    logic [15:0] fs_rpm_ff,  nxt_fs_rpm;
    logic [15:0] fld_trim_ff, nxt_fld_trim;
    logic [15:0] arm_trim_ff, nxt_arm_trim;
    logic [15:0] tch_trim_ff, nxt_tch_trim;
    logic [15:0] ir_ff,      nxt_ir;
    logic [15:0] fs_arm_ff,  nxt_fs_arm;
    logic        ack_ff,     nxt_ack;
    logic [31:0] rdat_ff,    nxt_rdat;
    // Decoder and measurement state
    logic [1:0]         sync1_ff, nxt_sync1;   // First synchroniser stage
    logic [1:0]         sync2_ff, nxt_sync2;   // Second stage, safe to use
    logic [1:0]         prev_ff,  nxt_prev;    // Last sampled level pair
    logic signed [23:0] cnt_ff,   nxt_cnt;     // Signed edges this gate
    logic [31:0]        gate_ff,  nxt_gate;    // Gate cycle counter
    logic signed [31:0] rpm_ff,   nxt_rpm;
    logic signed [31:0] mpct_ff,  nxt_mpct;
    logic signed [31:0] trim_ff,  nxt_trim;    // Encoder steady-state trim
    logic signed [31:0] spd_ff,   nxt_spd;
    logic signed [31:0] armp_ff,  nxt_armp;
    logic signed [31:0] tach_ff,  nxt_tach;
    logic signed [31:0] fld_ff,   nxt_fld;
    // Decoded control fields
    logic     quad_en;
    logic     dir_inv;
    logic     orient;
    fb_mode_t mode;
    logic     access;
    logic [7:0] ofs;
    assign quad_en = ctrl_ff[CTRL_QUAD];
    assign dir_inv = ctrl_ff[CTRL_INV];
    assign orient  = ctrl_ff[CTRL_ORIENT];
    assign mode    = fb_mode_t'(ctrl_ff[CTRL_MODE_LO +: 3]);
    assign access  = wb_cyc_i && wb_stb_i && !ack_ff;
    assign ofs     = wb_adr_i[7:0];
    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0])
            r[7:0] = d[7:0];
        if (s[1])
            r[15:8] = d[15:8];
        return r;
    endfunction : merge16
    // Bus slave next state: one-cycle ack, unmapped reads zero
    always_comb
    begin
        nxt_ctrl     = ctrl_ff;
        nxt_lines    = lines_ff;
        nxt_ratio    = ratio_ff;
        nxt_fs_rpm   = fs_rpm_ff;
        nxt_fld_trim = fld_trim_ff;
        nxt_arm_trim = arm_trim_ff;
        nxt_tch_trim = tch_trim_ff;
        nxt_ir       = ir_ff;
        nxt_fs_arm   = fs_arm_ff;
        nxt_ack      = access;
        nxt_rdat     = 32'h0000_0000;
        if (access && wb_we_i && wb_adr_i[31:8] == 24'h00_0000)
        begin
            // Unmapped writes acked, dropped
            if (ofs == OFS_CTRL && wb_sel_i[0])
                nxt_ctrl[7:0] = wb_dat_i[7:0] & 8'h77;
            else if (ofs == OFS_LINES) nxt_lines = merge16(lines_ff, wb_dat_i, wb_sel_i);
            else if (ofs == OFS_RATIO) nxt_ratio = merge16(ratio_ff, wb_dat_i, wb_sel_i);
            else if (ofs == OFS_FS_RPM) nxt_fs_rpm = merge16(fs_rpm_ff, wb_dat_i, wb_sel_i);
            else if (ofs == OFS_FLD_TRIM)
                nxt_fld_trim = clamp_trim(merge16(fld_trim_ff, wb_dat_i, wb_sel_i));
            else if (ofs == OFS_ARM_TRIM)
                nxt_arm_trim = clamp_trim(merge16(arm_trim_ff, wb_dat_i, wb_sel_i));
            else if (ofs == OFS_TACH_TRIM)
                nxt_tch_trim = clamp_trim(merge16(tch_trim_ff, wb_dat_i, wb_sel_i));
            else if (ofs == OFS_IR_COMP) nxt_ir = merge16(ir_ff, wb_dat_i, wb_sel_i);
            else if (ofs == OFS_FS_ARM) nxt_fs_arm = merge16(fs_arm_ff, wb_dat_i, wb_sel_i);
        end
        else if (access && wb_adr_i[31:8] == 24'h00_0000)
        begin
            // Reads give pre-edge values
            if (ofs == OFS_CTRL) nxt_rdat = ctrl_ff;
            else if (ofs == OFS_LINES) nxt_rdat = {16'h0000, lines_ff};
            else if (ofs == OFS_RATIO) nxt_rdat = {16'h0000, ratio_ff};
            else if (ofs == OFS_FS_RPM) nxt_rdat = {16'h0000, fs_rpm_ff};
            else if (ofs == OFS_FLD_TRIM) nxt_rdat = {16'h0000, fld_trim_ff};
            else if (ofs == OFS_ARM_TRIM) nxt_rdat = {16'h0000, arm_trim_ff};
            else if (ofs == OFS_TACH_TRIM) nxt_rdat = {16'h0000, tch_trim_ff};
            else if (ofs == OFS_IR_COMP) nxt_rdat = {16'h0000, ir_ff};
            else if (ofs == OFS_FS_ARM) nxt_rdat = {16'h0000, fs_arm_ff};
            else if (ofs == OFS_ENC_RPM) nxt_rdat = rpm_ff;
            else if (ofs == OFS_MOT_PCT) nxt_rdat = mpct_ff;
            else if (ofs == OFS_SPD_FB) nxt_rdat = spd_ff;
        end
    end

    // Bus slave registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff     <= CTRL_RST;
            lines_ff    <= LINES_RST;
            ratio_ff    <= RATIO_RST;
            fs_rpm_ff   <= FS_RPM_RST;
            fld_trim_ff <= TRIM_MIN;
            arm_trim_ff <= TRIM_MIN;
            tch_trim_ff <= TRIM_MIN;
            ir_ff       <= IR_RST;
            fs_arm_ff   <= FS_ARM_RST;
            ack_ff      <= 1'b0;
            rdat_ff     <= 32'h0000_0000;
        end
        else
        begin
            ctrl_ff     <= nxt_ctrl;
            lines_ff    <= nxt_lines;
            ratio_ff    <= nxt_ratio;
            fs_rpm_ff   <= nxt_fs_rpm;
            fld_trim_ff <= nxt_fld_trim;
            arm_trim_ff <= nxt_arm_trim;
            tch_trim_ff <= nxt_tch_trim;
            ir_ff       <= nxt_ir;
            fs_arm_ff   <= nxt_fs_arm;
            ack_ff      <= nxt_ack;
            rdat_ff     <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    // Decoder, gate and calibration next state.
    // Only a two-flop synchroniser, no glitch filter: short pulses must
    // survive, so noise immunity is left to clean wiring.
    always_comb
    begin
        logic               step;
        logic               fwd;
        logic               analog_neg;
        logic signed [23:0] delta;
        logic signed [31:0] mult;
        logic signed [31:0] arm_comp;
        logic signed [31:0] analog;
        step       = 1'b0;
        fwd        = 1'b0;
        analog_neg = 1'b0;
        delta      = 24'sd0;
        mult       = 32'sd1;
        arm_comp   = 32'sd0;
        analog     = (mode == FB_TACHO || mode == FB_ENC_TACHO) ? tach_ff : armp_ff;
        nxt_sync1  = {pulse_input_terminal_i, direction_input_terminal_i};
        nxt_sync2  = sync1_ff;
        nxt_prev   = sync2_ff;
        nxt_gate   = gate_ff + 32'd1;
        nxt_rpm    = rpm_ff;
        nxt_mpct   = mpct_ff;
        nxt_trim   = trim_ff;
        // Sign of analog feedback for combined single-line modes
        analog_neg = (mode == FB_ENC_TACHO) ? tacho_fb_i[15] : arm_volts_i[15];
        if (quad_en)
        begin
            // Any single-bit change is one edge of either train
            step = ^(sync2_ff ^ prev_ff);
            fwd  = sync2_ff[1] ^ prev_ff[0];
            mult = 32'sd4;
        end
        else
        begin
            step = sync2_ff[1] && !prev_ff[1];
            if ((mode == FB_ENC_ARM || mode == FB_ENC_TACHO) && !orient)
                fwd = !analog_neg;
            else
                fwd = sync2_ff[0];
        end
        if (dir_inv)
            fwd = !fwd;
        if (step)
            delta = fwd ? 24'sd1 : -24'sd1;
        nxt_cnt = cnt_ff + delta;
        // Gate end: latch speed, restart count from this cycle's edge
        if (gate_ff >= GATE_CYCLES - 1)
        begin
            nxt_gate = 32'd0;
            nxt_cnt  = delta;
            // rpm = edges * 60 s / (gate time * edges per rev)
            nxt_rpm  = sdiv(64'(cnt_ff) * 64'sd60 * 64'(CLK_HZ),
                            64'(GATE_CYCLES) * 64'(mult)
                            * $signed({48'h0, lines_ff}));
            nxt_mpct = sdiv(64'(rpm_ff) * $signed({48'h0, ratio_ff}) * 64'(PCT_FULL),
                            $signed({48'h0, fs_rpm_ff}) * 64'sd256);
            if (mode == FB_ENC_ARM || mode == FB_ENC_TACHO)
                nxt_trim = trim_ff + ((mpct_ff - trim_ff - analog) >>> 4);
            else
                nxt_trim = 32'sd0;
        end
        // Resistive drop removed from armature volts in modes 0 and 3, or under field weakening
        arm_comp = 32'(arm_volts_i);
        if (mode == FB_ARM_VOLTS || mode == FB_ENC_ARM || field_weak_i)
            arm_comp = 32'(arm_volts_i)
                       - 32'((48'(arm_current_i) * $signed({32'h0, ir_ff})) >>> 16);
        nxt_armp = sdiv(64'(trim_mul(arm_comp, arm_trim_ff)) * 64'(PCT_FULL),
                        $signed({48'h0, fs_arm_ff}));
        nxt_tach = trim_mul(32'(tacho_fb_i), tch_trim_ff);
        nxt_fld  = trim_mul(32'(field_fb_i), fld_trim_ff);
        // Selected speed feedback
        if (mode == FB_ENCODER)
            nxt_spd = mpct_ff;
        else if (mode == FB_ENC_ARM || mode == FB_ENC_TACHO)
            nxt_spd = analog + trim_ff;
        else
            nxt_spd = analog;
    end

    // Decoder, gate and calibration registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_ff <= 2'b00;
            sync2_ff <= 2'b00;
            prev_ff  <= 2'b00;
            cnt_ff   <= 24'sd0;
            gate_ff  <= 32'd0;
            rpm_ff   <= 32'sd0;
            mpct_ff  <= 32'sd0;
            trim_ff  <= 32'sd0;
            spd_ff   <= 32'sd0;
            armp_ff  <= 32'sd0;
            tach_ff  <= 32'sd0;
            fld_ff   <= 32'sd0;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
            cnt_ff   <= nxt_cnt;
            gate_ff  <= nxt_gate;
            rpm_ff   <= nxt_rpm;
            mpct_ff  <= nxt_mpct;
            trim_ff  <= nxt_trim;
            spd_ff   <= nxt_spd;
            armp_ff  <= nxt_armp;
            tach_ff  <= nxt_tach;
            fld_ff   <= nxt_fld;
        end
    end

    // Outputs straight from flip-flops
    assign encoder_speed_monitor_o = rpm_ff;
    assign motor_speed_percent_o   = mpct_ff;
    assign speed_feedback_o        = spd_ff;
    assign arm_fb_percent_o        = armp_ff;
    assign tacho_fb_trimmed_o      = tach_ff;
    assign field_fb_trimmed_o      = fld_ff;
endmodule : encoder_feedback_calibration

// >>> tb/enc_src_model.sv
// Encoder model: quadrature pair, or pulse train plus direction level.
// Assumes the bench picks format and direction and starts or stops the shaft.
`timescale 1ns/10ps
module enc_src_model
#(
    parameter int unsigned QUARTER = 250  // Quarter line; fast source
)
(
    input  wire logic clk_i,
    input  wire logic run_i,   // Shaft turning
    input  wire logic quad_i,  // Two-train format
    input  wire logic fwd_i,   // Forward rotation
    output logic      a_o,     // Pulse or A train
    output logic      b_o      // Direction or B train
);
    logic [1:0]  phase_ff = 2'h0;   // Quarter-line position
    logic [31:0] tick_ff  = 32'h0;  // Cycles within a quarter
    // One step per quarter, four per line: 100 kHz
    always_ff @(posedge clk_i)
    begin
        if (run_i && tick_ff == QUARTER - 1)
        begin
            tick_ff  <= 32'h0;
            phase_ff <= fwd_i ? phase_ff + 2'h1 : phase_ff - 2'h1;
        end
        else if (run_i)
        begin
            tick_ff <= tick_ff + 32'h1;
        end
    end
    // Forward: A rises while B low; stopped shaft holds
    always_comb
    begin
        a_o = quad_i ? (phase_ff == 2'h1 || phase_ff == 2'h2) : phase_ff[1];
        b_o = quad_i ? phase_ff[1] : fwd_i;
    end
endmodule : enc_src_model

// >>> tb/encoder_feedback_calibration_monitor.sv
// Checker on the ports of the encoder feedback block.
// Assumes classic Wishbone traffic; gate length comes via bind.
`timescale 1ns/10ps
module encoder_feedback_calibration_monitor
#(
    parameter int unsigned GATE_CYCLES = 1000  // Gate length
)
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               pulse_input_terminal_i,
    input wire logic               direction_input_terminal_i,
    input wire logic signed [15:0] tacho_fb_i,
    input wire logic signed [15:0] field_fb_i,
    input wire logic [31:0]        wb_adr_i,
    input wire logic               wb_we_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic signed [31:0] encoder_speed_monitor_o,
    input wire logic signed [31:0] motor_speed_percent_o,
    input wire logic signed [31:0] tacho_fb_trimmed_o,
    input wire logic signed [31:0] field_fb_trimmed_o
);
    logic [31:0]        since_ff, nxt_since;  // Cycles since speed last moved
    logic [31:0]        idle_ff, nxt_idle;    // Cycles since a pin last moved
    logic signed [31:0] rpm_ff;               // Speed one cycle ago
    logic [1:0]         pins_ff;              // Pins one cycle ago
    // Restart on change
    always_comb
    begin
        nxt_since = (encoder_speed_monitor_o != rpm_ff) ? 32'h0 : since_ff + 32'h1;
        nxt_idle  = ({pulse_input_terminal_i, direction_input_terminal_i} != pins_ff)
                    ? 32'h0 : idle_ff + 32'h1;
    end
    // Registers only
    always_ff @(posedge clk_i)
    begin
        since_ff <= rst_i ? 32'h0 : nxt_since;
        idle_ff  <= rst_i ? 32'h0 : nxt_idle;
        rpm_ff   <= encoder_speed_monitor_o;
        pins_ff  <= {pulse_input_terminal_i, direction_input_terminal_i};
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o && wb_dat_o == 32'h0;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
    property p_no_spur;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_no_spur: assert property (p_no_spur) else $error("ack without request");
    property p_rd_unmapped;
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[31:8] != 24'h0
            |=> wb_ack_o && wb_dat_o == 32'h0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    // Not disabled by reset
    property p_rst_zero;
        disable iff (1'b0) rst_i |=> !wb_ack_o && encoder_speed_monitor_o == 32'sh0
            && motor_speed_percent_o == 32'sh0;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("outputs not cleared by reset");
    property p_gate_hold;
        encoder_speed_monitor_o != rpm_ff |-> since_ff >= GATE_CYCLES - 2;
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("speed moved inside a gate");
    // Margin: percent lags a gate
    property p_idle_zero;
        idle_ff > 3 * GATE_CYCLES + 8 |-> encoder_speed_monitor_o == 32'sh0
            && motor_speed_percent_o == 32'sh0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("speed nonzero with no pulses");
    property p_trim_zero;
        (tacho_fb_i == 16'sh0 && field_fb_i == 16'sh0)[*3]
            |-> tacho_fb_trimmed_o == 32'sh0 && field_fb_trimmed_o == 32'sh0;
    endproperty
    a_trim_zero: assert property (p_trim_zero) else $error("trim of zero not zero");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_reverse: cover property (encoder_speed_monitor_o < 32'sh0);
    c_percent: cover property (motor_speed_percent_o > 32'sh0);
endmodule : encoder_feedback_calibration_monitor

bind encoder_feedback_calibration encoder_feedback_calibration_monitor
    #(.GATE_CYCLES(GATE_CYCLES)) i_encoder_feedback_calibration_monitor (.clk_i, .rst_i,
    .pulse_input_terminal_i, .direction_input_terminal_i, .tacho_fb_i, .field_fb_i,
    .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .encoder_speed_monitor_o, .motor_speed_percent_o, .tacho_fb_trimmed_o,
    .field_fb_trimmed_o);

// >>> tb/tb_encoder_feedback_calibration.sv
// Self-checking bench for the encoder feedback and calibration block.
// Assumes a short gate and the encoder model on the pins.
`timescale 1ns/10ps
module tb_encoder_feedback_calibration;
    import enc_cal_pkg::*;
    localparam int GATE    = 4000;  // Shortened gate keeps the run short
    localparam int QTR     = 250;   // 100 kHz line rate
    localparam int LINES   = 100;   // Lines per revolution
    localparam int EXP_RPM = CLK_HZ / (4 * QTR) * 60 / LINES;
    localparam int EXP_PCT = EXP_RPM * 5000 / 60000;  // Ratio 0.5, 60000 rpm
    logic               clk_i = 1'b0, rst_i = 1'b1;
    logic               run = 1'b0, quad = 1'b1, fwd = 1'b1, enc_a, enc_b;
    logic signed [15:0] arm_v = 16'sh0, arm_i = 16'sh0, tach = 16'sh0, fld = 16'sh0;
    logic               fweak = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
    logic [23:0]        page = 24'h0;  // Upper address bits
    logic [31:0]        adr = 32'h0, wdat = 32'h0, dat, q;
    logic signed [31:0] rpm, pct, spd_fb, arm_pct, tach_t, fld_t;
    int                 err_total = 0, samples_checked = 0, cycles = 0;
    encoder_feedback_calibration #(.GATE_CYCLES(GATE)) i_encoder_feedback_calibration (
        .clk_i(clk_i), .rst_i(rst_i), .pulse_input_terminal_i(enc_a),
        .direction_input_terminal_i(enc_b), .arm_volts_i(arm_v), .arm_current_i(arm_i),
        .tacho_fb_i(tach), .field_fb_i(fld), .field_weak_i(fweak), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(dat), .wb_ack_o(ack), .encoder_speed_monitor_o(rpm),
        .motor_speed_percent_o(pct), .speed_feedback_o(spd_fb), .arm_fb_percent_o(arm_pct),
        .tacho_fb_trimmed_o(tach_t), .field_fb_trimmed_o(fld_t));
    enc_src_model #(.QUARTER(QTR)) i_enc_src_model (.clk_i(clk_i), .run_i(run),
        .quad_i(quad), .fwd_i(fwd), .a_o(enc_a), .b_o(enc_b));
    always #5 clk_i = ~clk_i;
    // One comparison
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    function automatic logic near(input logic signed [31:0] v, input int e, input int t);
        return (v >= e - t) && (v <= e + t);
    endfunction : near
    // Classic cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {page, a};
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 20) chk(1'b0, "no ack");
    endtask : wb
    // Reset values, clamps, unmapped read
    task automatic t_regs();
        wb(0, OFS_CTRL, 0);       chk(q === CTRL_RST, "ctrl reset");
        wb(0, OFS_TACH_TRIM, 0);  chk(q === 32'(TRIM_MIN), "trim reset");
        wb(1, OFS_TACH_TRIM, 32'h7000);
        wb(0, OFS_TACH_TRIM, 0);  chk(q === 32'(TRIM_MAX), "trim high clamp");
        wb(1, OFS_FLD_TRIM, 32'h1000);
        wb(0, OFS_FLD_TRIM, 0);   chk(q === 32'(TRIM_MIN), "trim low clamp");
        page = 24'h1;
        wb(0, OFS_CTRL, 0);       chk(q === 32'h0, "unmapped read");
        page = 24'h0;
        wb(1, OFS_LINES, LINES);
        wb(1, OFS_RATIO, 32'h0080);
        wb(1, OFS_FS_RPM, 32'hea60);
        $display("test regs done");
    endtask : t_regs
    // Settle, then compare arm percent
    task automatic arm_is(input int e, input string m);
        repeat (4) @(posedge clk_i);
        chk(near(arm_pct, e, 1), m);
    endtask : arm_is
    task automatic t_analog();
        @(posedge clk_i);
        arm_v <= 16'sd200;
        tach  <= 16'sd1000;
        fld   <= 16'sd500;
        arm_is(5000, "arm full scale");
        chk(near(tach_t, 1099, 1), "tacho trim");
        chk(fld_t === 32'sd500, "field trim");
        wb(1, OFS_IR_COMP, 32'h8000);
        arm_i <= 16'sd100;
        arm_is(3750, "drop applied");
        wb(1, OFS_CTRL, 32'h10);
        arm_is(5000, "drop off in tacho mode");
        chk(near(spd_fb, 1099, 1), "tacho feedback");
        fweak <= 1'b1;
        arm_is(3750, "drop on with weakening");
        fweak <= 1'b0;
        $display("test analog done");
    endtask : t_analog
    // Spin, wait three gates, compare
    task automatic t_enc(input logic q4, input logic f, input logic [7:0] c,
                         input int sgn, input string nm);
        int tol;
        tol = EXP_RPM * QTR * (q4 ? 1 : 4) / GATE + 1;
        @(posedge clk_i);
        quad <= q4;
        fwd  <= f;
        run  <= 1'b1;
        wb(1, OFS_CTRL, {24'h0, c});
        repeat (3 * GATE + 20) @(posedge clk_i);
        chk(near(rpm, sgn * EXP_RPM, tol), {nm, " rpm"});
        chk(near(pct, sgn * EXP_PCT, tol / 12 + 2), {nm, " percent"});
        $display("test %s done", nm);
    endtask : t_enc
    task automatic t_zero();
        @(posedge clk_i);
        run <= 1'b0;
        repeat (4 * GATE) @(posedge clk_i);
        chk(rpm === 32'sh0, "idle rpm");
        chk(pct === 32'sh0, "idle percent");
        $display("test idle done");
    endtask : t_zero
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_analog();
        t_enc(1, 1, 8'h01, 1, "quad fwd");
        t_enc(1, 0, 8'h01, -1, "quad rev");
        t_enc(1, 0, 8'h03, 1, "quad rev inv");
        t_enc(0, 0, 8'h00, -1, "single low");
        t_enc(0, 0, 8'h30, 1, "mode3 single");
        t_enc(0, 0, 8'h42, -1, "mode4 inv");
        t_zero();
        tally_and_finish();
    end
endmodule : tb_encoder_feedback_calibration
